// ===== verilog/hdrom_top.sv
// descriptor server and status endpoint answer for the hub
// assumes setup and token inputs come from same-clock endpoint logic;
// straps and mode pins come from outside and are synchronised here
`timescale 1ns/1ps
module hdrom_top
(
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire logic                     high_speed,
	input  wire hdrom_pkg::hdrom_pins_type pins_async,
	input  wire logic                     setup_valid,
	output      logic                     setup_ready,
	input  wire hdrom_pkg::hdrom_setup_type setup,
	output      logic                     req_stall_ff,
	output      logic                     req_zlp_ff,
	output      logic                     beat_valid,
	input  wire logic                     beat_ready,
	output      hdrom_pkg::hdrom_beat_type beat_ff,
	input  wire logic                     sts_in_token,
	input  wire logic [4:0]               sts_change,
	output      logic                     sts_nak_ff,
	output      logic                     sts_send_ff,
	output      logic [7:0]               sts_byte_ff
);
	import hdrom_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_LOAD,
		ST_SEND
	} hdrom_state_type;

	hdrom_state_type state_ff;
	hdrom_pins_type  pins_meta_ff;
	hdrom_pins_type  pins_sync_ff;
	hdrom_pins_type  pins_ff;
	logic [1:0]      pins_fill_ff;
	logic            pins_taken_ff;
	logic [4:0]      rd_addr_ff;
	logic [3:0]      remain_ff;
	logic [7:0]      rom_data;
	logic [7:0]      patched;
	logic [7:0]      char_byte;
	logic [7:0]      port_count;
	hdrom_sel_type   sel;
	logic [3:0]      sel_len;
	logic [4:0]      sel_base;
	logic [3:0]      nxt_len;
	logic            take;
	logic            give;

	// only descriptor reads reach this block; anything else is refused
	function automatic hdrom_sel_type decode(input hdrom_setup_type s);
		decode = SEL_NONE;
		if (s.b_request == REQ_GET_DESC)
		begin
			if (s.bm_request_type == RT_STD_IN &&
			    s.w_value[15:8] == DT_INTERFACE)
				decode = SEL_IF;
			else if (s.bm_request_type == RT_STD_IN &&
			         s.w_value[15:8] == DT_ENDPOINT)
				decode = SEL_EP;
			else if (s.bm_request_type == RT_CLASS_IN &&
			         s.w_value[15:8] == DT_HUB)
				decode = SEL_HUB;
		end
	endfunction

	hdrom_mem u_mem
	(
		.core_clk   (core_clk),
		.reset      (reset),
		.rd_addr    (rd_addr_ff),
		.rd_data_ff (rom_data)
	);

	// two-stage sync; the first stage feeds nothing but the second
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			pins_meta_ff <= PIN_RESET;
			pins_sync_ff <= PIN_RESET;
			pins_fill_ff <= 2'h0;
		end
		else
		begin
			pins_meta_ff <= pins_async;
			pins_sync_ff <= pins_meta_ff;
			// marks the edge from which stage two holds real pin values
			pins_fill_ff <= {pins_fill_ff[0], 1'b1};
		end
	end

	// straps are frozen once after reset so the port count cannot change
	// under a host that has already read it
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			pins_ff       <= PIN_RESET;
			pins_taken_ff <= 1'b0;
		end
		else if (!pins_taken_ff && pins_fill_ff[1])
		begin
			// latching earlier would freeze the reset value, not the straps
			pins_ff       <= pins_sync_ff;
			pins_taken_ff <= 1'b1;
		end
	end

	always_comb
	begin
		if (pins_ff.port3_strap && pins_ff.port4_strap)
			port_count = PORTS_2; // see R4
		else if (pins_ff.port4_strap)
			port_count = PORTS_3; // see R4
		else
			port_count = PORTS_4; // see R4
	end

	always_comb
	begin
		char_byte = CHAR_DEFAULT;
		char_byte[CHAR_PWR_LSB +: 2] = {1'b0, pins_ff.pwr_individual}; // see R7
		char_byte[CHAR_CMP_BIT] = pins_ff.compound; // see R8
		char_byte[CHAR_OCP_LSB +: 2] = pins_ff.ocp_mode; // see R9
		char_byte[CHAR_IND_BIT] = 1'b0; // see R8
	end

	// rd_addr_ff has not moved since the fetch, so it still names rom_data
	always_comb
	begin
		case (rd_addr_ff)
			EP_IVAL_ADDR:   patched = high_speed ? IVAL_HS : IVAL_FS; // see R3 see R11
			HUB_NPORT_ADDR: patched = port_count;
			HUB_CHAR_ADDR:  patched = char_byte;
			default:        patched = rom_data;
		endcase
	end

	always_comb
	begin
		sel = decode(setup); // see R10
		case (sel)
			SEL_IF:
			begin
				sel_len  = IF_LEN;
				sel_base = IF_BASE;
			end
			SEL_EP:
			begin
				sel_len  = EP_LEN;
				sel_base = EP_BASE;
			end
			SEL_HUB:
			begin
				sel_len  = HUB_LEN;
				sel_base = HUB_BASE;
			end
			default:
			begin
				sel_len  = 4'h0;
				sel_base = IF_BASE;
			end
		endcase
		if (setup.w_length < {12'h000, sel_len})
			nxt_len = setup.w_length[3:0]; // see R13
		else
			nxt_len = sel_len;
	end

	assign setup_ready = (state_ff == ST_IDLE);
	assign take        = setup_valid && setup_ready;
	assign beat_valid  = (state_ff == ST_SEND);
	assign give        = beat_valid && beat_ready;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_ff   <= ST_IDLE;
			rd_addr_ff <= IF_BASE;
			remain_ff  <= 4'h0;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
					if (take && sel != SEL_NONE && nxt_len != 4'h0)
					begin
						rd_addr_ff <= sel_base;
						remain_ff  <= nxt_len;
						state_ff   <= ST_WAIT;
					end
				ST_WAIT:
					state_ff <= ST_LOAD;
				ST_LOAD:
					state_ff <= ST_SEND;
				ST_SEND:
					if (give)
					begin
						remain_ff <= remain_ff - 4'h1;
						if (remain_ff == 4'h1)
							state_ff <= ST_IDLE;
						else
						begin
							// ascending address keeps low byte first
							rd_addr_ff <= rd_addr_ff + 5'h01; // see R13
							state_ff   <= ST_WAIT;
						end
					end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			beat_ff <= '0;
		else if (state_ff == ST_LOAD)
		begin
			beat_ff.data <= patched;
			beat_ff.last <= (remain_ff == 4'h1); // see R13
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			req_stall_ff <= 1'b0;
			req_zlp_ff   <= 1'b0;
		end
		else
		begin
			req_stall_ff <= take && (sel == SEL_NONE); // see R10
			req_zlp_ff   <= take && (sel != SEL_NONE) && (nxt_len == 4'h0);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sts_nak_ff  <= 1'b0;
			sts_send_ff <= 1'b0;
			sts_byte_ff <= 8'h00;
		end
		else
		begin
			sts_nak_ff  <= sts_in_token && (sts_change == 5'h00); // see R12
			sts_send_ff <= sts_in_token && (sts_change != 5'h00); // see R12
			if (sts_in_token)
				sts_byte_ff <= {3'h0, sts_change}; // see R12
		end
	end
endmodule

// ===== include/hdrom_pkg.sv
// constants, types and descriptor layout for the hub descriptor block
// assumes one core clock and a synchronous active-high reset
// What this block does
// R1 - interface descriptor: 9 bytes, type 04, one endpoint, hub class 09
// R2 - endpoint descriptor: 7 bytes, type 05, address 81, interrupt attributes 03
// R3 - status endpoint max packet one byte; interval FF full speed, 0C high
// R4 - hub descriptor type 29, 9 bytes, port count 04/03/02 from straps
// R5 - power-on to power-good reported as 32 (units of 2 ms, 100 ms)
// R6 - removable mask 00, port power mask FF, controller current 64
// R7 - characteristics D1:D0 power switching: 00 ganged, 01 individual
// R8 - characteristics D2 compound flag; D7 reads 0
// R9 - characteristics D4:D3 overcurrent: 00 global, 01 individual, 10 none
// R10 - answer host control requests for these descriptors, refuse the rest
// R11 - pick field values by current operating speed
// R12 - status endpoint IN: NAK without change, else send change bitmap
// R13 - multi-byte fields low byte first; truncate to requested length
package hdrom_pkg;
	localparam logic [7:0] DT_INTERFACE   = 8'h04;
	localparam logic [7:0] DT_ENDPOINT    = 8'h05;
	localparam logic [7:0] DT_HUB         = 8'h29;
	localparam logic [7:0] RT_STD_IN      = 8'h80;
	localparam logic [7:0] RT_CLASS_IN    = 8'hA0;
	localparam logic [7:0] REQ_GET_DESC   = 8'h06;
	localparam logic [7:0] HUB_CLASS      = 8'h09;
	localparam logic [7:0] EP_ADDR_IN1    = 8'h81;
	localparam logic [7:0] EP_ATTR_INTR   = 8'h03;
	localparam logic [7:0] EP_MAXPKT      = 8'h01;
	localparam logic [7:0] IVAL_FS        = 8'hFF;
	localparam logic [7:0] IVAL_HS        = 8'h0C;
	localparam logic [7:0] PORTS_4        = 8'h04;
	localparam logic [7:0] PORTS_3        = 8'h03;
	localparam logic [7:0] PORTS_2        = 8'h02;
	localparam logic [7:0] CHAR_DEFAULT   = 8'hA9;
	localparam logic [7:0] PWR_GOOD_TIME  = 8'h32;
	localparam logic [7:0] CTRL_CURRENT   = 8'h64;
	localparam logic [7:0] REMOVABLE_MASK = 8'h00;
	localparam logic [7:0] PWR_CTRL_MASK  = 8'hFF;
	localparam logic [3:0] IF_LEN         = 4'h9;
	localparam logic [3:0] EP_LEN         = 4'h7;
	localparam logic [3:0] HUB_LEN        = 4'h9;
	localparam logic [4:0] IF_BASE        = 5'h00;
	localparam logic [4:0] EP_BASE        = 5'h09;
	localparam logic [4:0] HUB_BASE       = 5'h10;
	localparam logic [4:0] ROM_LAST       = 5'h18;
	localparam logic [4:0] EP_IVAL_ADDR   = 5'h0F;
	localparam logic [4:0] HUB_NPORT_ADDR = 5'h12;
	localparam logic [4:0] HUB_CHAR_ADDR  = 5'h13;
	localparam int         CHAR_PWR_LSB   = 0;
	localparam int         CHAR_CMP_BIT   = 2;
	localparam int         CHAR_OCP_LSB   = 3;
	localparam int         CHAR_IND_BIT   = 7;
	localparam int         PIN_W          = 6;
	localparam logic [PIN_W-1:0] PIN_RESET = 6'h00;
	localparam logic [1:0] OCP_GLOBAL     = 2'h0;
	localparam logic [1:0] OCP_INDIV      = 2'h1;
	localparam logic [1:0] OCP_NONE       = 2'h2;

	typedef struct packed {
		logic [7:0]  bm_request_type;
		logic [7:0]  b_request;
		logic [15:0] w_value;
		logic [15:0] w_index;
		logic [15:0] w_length;
	} hdrom_setup_type;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} hdrom_beat_type;

	typedef struct packed {
		logic       port4_strap;
		logic       port3_strap;
		logic       pwr_individual;
		logic       compound;
		logic [1:0] ocp_mode;
	} hdrom_pins_type;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_IF,
		SEL_EP,
		SEL_HUB
	} hdrom_sel_type;
endpackage

// ===== verilog/hdrom_mem.sv
// fixed descriptor image with registered read data
// assumes the caller patches the speed and strap dependent bytes
`timescale 1ns/1ps
module hdrom_mem
(
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic [4:0] rd_addr,
	output      logic [7:0] rd_data_ff
);
	import hdrom_pkg::*;

	function automatic logic [7:0] image(input logic [4:0] a);
		case (a)
			5'h00: image = {4'h0, IF_LEN};
			5'h01: image = DT_INTERFACE;
			5'h04: image = 8'h01;
			5'h05: image = HUB_CLASS;
			5'h09: image = {4'h0, EP_LEN};
			5'h0A: image = DT_ENDPOINT;
			5'h0B: image = EP_ADDR_IN1;
			5'h0C: image = EP_ATTR_INTR;
			5'h0D: image = EP_MAXPKT;
			5'h0F: image = IVAL_FS;
			5'h10: image = {4'h0, HUB_LEN};
			5'h11: image = DT_HUB;
			5'h12: image = PORTS_4;
			5'h13: image = CHAR_DEFAULT;
			5'h15: image = PWR_GOOD_TIME;
			5'h16: image = CTRL_CURRENT;
			5'h17: image = REMOVABLE_MASK;
			5'h18: image = PWR_CTRL_MASK;
			default: image = 8'h00;
		endcase
	endfunction

	always_ff @(posedge core_clk)
	begin
		if (reset)
			rd_data_ff <= 8'h00;
		else
			rd_data_ff <= image(rd_addr); // see R1 see R2 see R5 see R6
	end
endmodule

// ===== bench/hdrom_properties.sv
// concurrent checks on the hub descriptor block's ports
// assumes one core clock and synchronous active-high reset
`timescale 1ns/1ps
module hdrom_chk
(
	input wire logic                       core_clk,
	input wire logic                       reset,
	input wire logic                       setup_valid,
	input wire logic                       setup_ready,
	input wire hdrom_pkg::hdrom_setup_type setup,
	input wire logic                       req_stall_ff,
	input wire logic                       req_zlp_ff,
	input wire logic                       beat_valid,
	input wire logic                       beat_ready,
	input wire hdrom_pkg::hdrom_beat_type  beat_ff,
	input wire logic                       sts_in_token,
	input wire logic [4:0]                 sts_change,
	input wire logic                       sts_nak_ff,
	input wire logic                       sts_send_ff,
	input wire logic [7:0]                 sts_byte_ff
);
	logic tk;
	assign tk = setup_valid && setup_ready;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_stall;
		tk && setup.bm_request_type == 8'h00 |=> req_stall_ff && !beat_valid;
	endproperty
	a_stall: assert property (p_stall) else $error("no stall");
	property p_zlp;
		tk && setup.bm_request_type == 8'hA0 && setup.b_request == 8'h06
		&& setup.w_value[15:8] == 8'h29 && setup.w_length == 16'h0000
		|=> req_zlp_ff;
	endproperty
	a_zlp: assert property (p_zlp) else $error("no zlp");
	property p_hub_first;
		tk && setup.bm_request_type == 8'hA0 && setup.b_request == 8'h06
		&& setup.w_value[15:8] == 8'h29 && setup.w_length != 16'h0000
		|=> !beat_valid ##1 !beat_valid ##1 beat_valid && beat_ff.data == 8'h09;
	endproperty
	a_hub_first: assert property (p_hub_first) else $error("hub len");
	property p_trunc;
		tk && setup.bm_request_type == 8'h80 && setup.b_request == 8'h06
		&& setup.w_value[15:8] == 8'h05 && setup.w_length == 16'h0001
		|=> ##2 beat_valid && beat_ff.last && beat_ff.data == 8'h07;
	endproperty
	a_trunc: assert property (p_trunc) else $error("no trunc");
	property p_busy;
		beat_valid |-> !setup_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("ready in send");
	property p_hold;
		beat_valid && !beat_ready |=> beat_valid && $stable(beat_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("beat lost");
	property p_nak;
		sts_in_token && sts_change == 5'h00 |=> sts_nak_ff && !sts_send_ff;
	endproperty
	a_nak: assert property (p_nak) else $error("no nak");
	property p_send;
		sts_in_token && sts_change != 5'h00
		|=> sts_send_ff && sts_byte_ff == {3'h0, $past(sts_change)};
	endproperty
	a_send: assert property (p_send) else $error("bad send");
endmodule
bind hdrom_top hdrom_chk chk_u (.core_clk, .reset, .setup_valid,
	.setup_ready, .setup, .req_stall_ff, .req_zlp_ff, .beat_valid,
	.beat_ready, .beat_ff, .sts_in_token, .sts_change, .sts_nak_ff,
	.sts_send_ff, .sts_byte_ff);

// ===== bench/hdrom_host.sv
// upstream host side: takes descriptor bytes, optionally stalling
// assumes the bench clears got before each request
`timescale 1ns/1ps
module hdrom_host
(
	input  wire logic                      core_clk,
	input  wire logic                      slow,
	input  wire logic                      beat_valid,
	input  wire hdrom_pkg::hdrom_beat_type beat_ff,
	output      logic                      beat_ready
);
	import hdrom_pkg::*;
	hdrom_beat_type got[$];
	initial beat_ready = 1'b0;
	always @(posedge core_clk)
	begin
		if (beat_valid && beat_ready)
		begin
			got.push_back(beat_ff);
		end
		// a slow host toggles ready so the device must hold each byte
		beat_ready <= slow ? !beat_ready : 1'b1;
	end
endmodule

// ===== bench/hub_descriptor_rom_tb_top.sv
// self-checking bench for the hub descriptor block
// assumes straps start at zero: four ports, ganged, global;
// one scenario restraps the pins twice, each across a mid-run reset
`timescale 1ns/1ps
module hub_descriptor_rom_tb_top;
	import hdrom_pkg::*;
	logic            core_clk = 1'b0;
	logic            reset = 1'b1;
	logic            high_speed = 1'b0;
	logic            slow = 1'b1;
	hdrom_pins_type  pins_async = '0;
	logic            setup_valid = 1'b0;
	hdrom_setup_type setup = '0;
	logic            sts_in_token = 1'b0;
	logic [4:0]      sts_change = 5'h00;
	logic            setup_ready, req_stall_ff, req_zlp_ff, beat_valid;
	logic            beat_ready, sts_nak_ff, sts_send_ff;
	logic [7:0]      sts_byte_ff;
	hdrom_beat_type  beat_ff;
	int              errors = 0;
	int              checks = 0;
	always #5 core_clk = !core_clk;
	hdrom_top dut_u (.core_clk, .reset, .high_speed, .pins_async,
		.setup_valid, .setup_ready, .setup, .req_stall_ff, .req_zlp_ff,
		.beat_valid, .beat_ready, .beat_ff, .sts_in_token, .sts_change,
		.sts_nak_ff, .sts_send_ff, .sts_byte_ff);
	hdrom_host host_u (.core_clk, .slow, .beat_valid, .beat_ff,
		.beat_ready);
	task automatic cmp8(input string nm, input logic [7:0] e, g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmp1(input string nm, input logic e, g);
		cmp8(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic get(input logic [7:0] bm, dt, input logic [15:0] len,
		input logic [71:0] exp, input int n);
		int k = 0;
		host_u.got.delete();
		@(posedge core_clk);
		setup_valid <= 1'b1;
		setup <= '{bm, REQ_GET_DESC, {dt, 8'h00}, 16'h0000, len};
		@(posedge core_clk);
		setup_valid <= 1'b0;
		// stall and zlp are one-cycle pulses launched by the take edge
		#1;
		cmp1("stall", n < 0, req_stall_ff);
		cmp1("zlp", n == 0, req_zlp_ff);
		while (n > 0 && k < 99 && !(setup_ready && host_u.got.size() == n))
		begin
			@(posedge core_clk);
			#1;
			k++;
		end
		cmp8("count", 8'(n > 0 ? n : 0), 8'(host_u.got.size()));
		for (int i = 0; i < n; i++)
		begin
			cmp8("byte", exp[71-8*i -: 8], host_u.got[i].data);
			cmp1("last", i == n - 1, host_u.got[i].last);
		end
	endtask
	task automatic strap_reset(input hdrom_pins_type p);
		@(posedge core_clk);
		pins_async <= p;
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		// two sync stages plus the latch edge before straps are seen
		repeat (4) @(posedge core_clk);
	endtask
	task automatic t_iface;
		get(8'h80, 8'h04, 16'hFFFF, 72'h09_04_00_00_01_09_00_00_00, 9);
	endtask
	task automatic t_endp;
		get(8'h80, 8'h05, 16'h0040, 72'h07_05_81_03_01_00_FF_00_00,
			7);
		high_speed <= 1'b1;
		get(8'h80, 8'h05, 16'h0007, 72'h07_05_81_03_01_00_0C_00_00,
			7);
	endtask
	task automatic t_hub;
		// characteristics: A9 with D0..D4 from zero pins and D7 cleared
		get(8'hA0, 8'h29, 16'h0009, 72'h09_29_04_20_00_32_64_00_FF,
			9);
	endtask
	task automatic t_straps;
		// both spare ports off, individual power, compound, no protection
		strap_reset('{1'b1, 1'b1, 1'b1, 1'b1, OCP_NONE});
		get(8'hA0, 8'h29, 16'h0009, 72'h09_29_02_35_00_32_64_00_FF,
			9);
		// port four off, ganged, individual protection; fast host
		strap_reset('{1'b1, 1'b0, 1'b0, 1'b0, OCP_INDIV});
		slow <= 1'b0;
		get(8'hA0, 8'h29, 16'h0009, 72'h09_29_03_28_00_32_64_00_FF,
			9);
	endtask
	task automatic t_trunc;
		get(8'h80, 8'h04, 16'h0003, 72'h09_04_00_00_00_00_00_00_00, 3);
		get(8'h80, 8'h05, 16'h0001, 72'h07_00_00_00_00_00_00_00_00, 1);
		get(8'hA0, 8'h29, 16'h0000, 72'h0, 0);
	endtask
	task automatic t_refuse;
		get(8'h00, 8'h29, 16'h0009, 72'h0, -1);
		get(8'h80, 8'h29, 16'h0009, 72'h0, -1);
	endtask
	task automatic t_status;
		@(posedge core_clk);
		sts_in_token <= 1'b1;
		sts_change <= 5'h00;
		@(posedge core_clk);
		sts_change <= 5'h12;
		#1;
		cmp1("nak", 1'b1, sts_nak_ff);
		@(posedge core_clk);
		sts_in_token <= 1'b0;
		#1;
		cmp1("send", 1'b1, sts_send_ff);
		cmp8("sts", 8'h12, sts_byte_ff);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		t_iface();
		t_endp();
		t_hub();
		t_trunc();
		t_refuse();
		t_straps();
		t_status();
		tally_and_finish();
	end
	// whole run needs well under a thousand cycles
	initial
	begin
		#20000;
		errors++;
		tally_and_finish();
	end
endmodule
